// ===== src/rsi_pkg.sv
// What this block does
// - The watchdog expiry flag and power-down entered flag are kept here, set by sleep/idle entry and the watchdog, and changed per reset type.
// - A power-on reset clears both flags to 0.
// - A low-supply reset in fast or slow mode leaves both flags unchanged.
// - A watchdog reset in fast or slow mode sets the expiry flag to 1 and leaves the power-down flag unchanged.
// - A watchdog reset in idle or sleep mode sets both flags to 1.
// - After power-on reset every interrupt source is disabled until software enables it.
// - After power-on reset the watchdog and time base counters are cleared and the watchdog then starts counting.
// - After power-on reset all timer modules are switched off.
// - After power-on reset every I/O pin is an input.
// - After power-on reset the stack pointer points at the top of the stack.
// - The program counter is loaded with 0000H after power-on, low-supply and watchdog resets.
// - A watchdog reset in sleep or idle clears program counter and stack pointer and leaves other state alone.
// - The low-supply reset fires only after the low condition outlasts its qualification time and is off in sleep and idle.
package rsi_pkg;
  localparam int          PC_W          = 13;
  localparam int          SP_W          = 4;
  localparam logic [12:0] PC_RESET      = 13'h0000;
  localparam logic [3:0]  SP_TOP        = 4'hF;
  localparam logic [3:0]  SP_CLEAR      = 4'h0;
  localparam int          SUPPLY_QUAL_NS  = 1000;
  localparam int          CLK_PERIOD_NS   = 40;
  // Least time, rounded up
  localparam int          SUPPLY_QUAL_CYC = (SUPPLY_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          QUAL_W        = 8;
endpackage : rsi_pkg

// ===== src/rsi_reset_init.sv
`timescale 1ns/1ps
module rsi_reset_init (
  // Clock and power-on reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      clk_en,
  // Reset sources and power mode
  input  wire logic                      low_supply,
  input  wire logic                      watchdog_timeout,
  input  wire logic                      low_power_mode,
  input  wire logic                      powerdown_enter,
  input  wire logic                      clear_watchdog,
  // Reset state
  output logic                           core_reset_q,
  output logic                           watchdog_expiry_flag_q,
  output logic                           powerdown_entered_flag_q,
  output logic [rsi_pkg::PC_W-1:0]       pc_load_q,
  output logic [rsi_pkg::SP_W-1:0]       sp_load_q,
  output logic                           state_load_q,
  output logic                           full_init_q,
  output logic                           low_supply_reset_q,
  output logic                           watchdog_clear_q
);
  // Which reset, if any, this cycle starts; one-hot so each output block tests its own case
  typedef enum logic [4:0] {
    RSI_CAUSE_NONE      = 5'h01,
    RSI_CAUSE_RELEASE   = 5'h02,
    RSI_CAUSE_DOG_RUN   = 5'h04,
    RSI_CAUSE_DOG_SLEEP = 5'h08,
    RSI_CAUSE_SUPPLY    = 5'h10
  } rsi_cause_e;

  logic [rsi_pkg::QUAL_W-1:0] qual_q;
  logic                       supply_fire;
  logic                       run_q;
  rsi_cause_e                 cause;

  // Low supply must persist the qualification time; disabled in low power
  assign supply_fire = low_supply && !low_power_mode
                       && (qual_q >= rsi_pkg::QUAL_W'(rsi_pkg::SUPPLY_QUAL_CYC - 1));

  // The count restarts on any drop, so a dip shorter than the window never accumulates
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      qual_q <= '0;
    end else if (clk_en) begin
      if (!low_supply || low_power_mode || supply_fire) begin
        qual_q <= '0;
      end else begin
        qual_q <= qual_q + 1'b1;
      end
    end
  end

  // Priority: watchdog, then qualified low supply; the first cycle after release is the power-on start
  always_comb begin
    cause = RSI_CAUSE_NONE;
    if (!run_q) begin
      cause = RSI_CAUSE_RELEASE;
    end else if (watchdog_timeout && low_power_mode) begin
      cause = RSI_CAUSE_DOG_SLEEP;
    end else if (watchdog_timeout) begin
      cause = RSI_CAUSE_DOG_RUN;
    end else if (supply_fire) begin
      cause = RSI_CAUSE_SUPPLY;
    end
  end

  // Marks the first enabled edge after power-on release
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
    end else if (clk_en) begin
      run_q <= 1'b1;
    end
  end

  // Expiry flag: power-on clears, watchdog sets, sleep entry and watchdog clear reset it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      watchdog_expiry_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (watchdog_timeout) begin
        watchdog_expiry_flag_q <= 1'b1;
      end else if (supply_fire) begin
        watchdog_expiry_flag_q <= watchdog_expiry_flag_q;
      end else if (powerdown_enter || clear_watchdog) begin
        watchdog_expiry_flag_q <= 1'b0;
      end
    end
  end

  // Power-down flag: a set from the watchdog or sleep entry wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      powerdown_entered_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (watchdog_timeout) begin
        if (low_power_mode) begin
          powerdown_entered_flag_q <= 1'b1;
        end else begin
          powerdown_entered_flag_q <= powerdown_entered_flag_q;
        end
      end else if (supply_fire) begin
        powerdown_entered_flag_q <= powerdown_entered_flag_q;
      end else if (powerdown_enter) begin
        powerdown_entered_flag_q <= 1'b1;
      end else if (clear_watchdog) begin
        powerdown_entered_flag_q <= 1'b0;
      end
    end
  end

  // One-cycle reset pulse to the core for each source; a level while nrst is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      core_reset_q <= 1'b1;
    end else if (clk_en) begin
      unique case (cause)
        RSI_CAUSE_NONE,
        RSI_CAUSE_RELEASE: begin
          core_reset_q <= 1'b0;
        end
        RSI_CAUSE_DOG_RUN,
        RSI_CAUSE_DOG_SLEEP,
        RSI_CAUSE_SUPPLY: begin
          core_reset_q <= 1'b1;
        end
      endcase
    end
  end

  // Core loads pc and sp on release and on every source reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_load_q <= 1'b0;
    end else if (clk_en) begin
      unique case (cause)
        RSI_CAUSE_NONE: begin
          state_load_q <= 1'b0;
        end
        RSI_CAUSE_RELEASE,
        RSI_CAUSE_DOG_RUN,
        RSI_CAUSE_DOG_SLEEP,
        RSI_CAUSE_SUPPLY: begin
          state_load_q <= 1'b1;
        end
      endcase
    end
  end

  // Full init turns interrupts and timers off and ports to inputs; the sleep watchdog skips it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      full_init_q <= 1'b1;
    end else if (clk_en) begin
      unique case (cause)
        RSI_CAUSE_NONE,
        RSI_CAUSE_RELEASE: begin
          full_init_q <= 1'b0;
        end
        RSI_CAUSE_DOG_SLEEP: begin
          full_init_q <= 1'b0; // Other state kept
        end
        RSI_CAUSE_DOG_RUN,
        RSI_CAUSE_SUPPLY: begin
          full_init_q <= 1'b1;
        end
      endcase
    end
  end

  // Every reset type starts execution at the same address
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pc_load_q <= rsi_pkg::PC_RESET;
    end else if (clk_en) begin
      unique case (cause)
        RSI_CAUSE_NONE,
        RSI_CAUSE_RELEASE: begin
          pc_load_q <= pc_load_q;
        end
        RSI_CAUSE_DOG_RUN,
        RSI_CAUSE_DOG_SLEEP,
        RSI_CAUSE_SUPPLY: begin
          pc_load_q <= rsi_pkg::PC_RESET;
        end
      endcase
    end
  end

  // Stack pointer: top of stack, except cleared by the sleep watchdog
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sp_load_q <= rsi_pkg::SP_TOP;
    end else if (clk_en) begin
      unique case (cause)
        RSI_CAUSE_NONE,
        RSI_CAUSE_RELEASE: begin
          sp_load_q <= sp_load_q;
        end
        RSI_CAUSE_DOG_SLEEP: begin
          sp_load_q <= rsi_pkg::SP_CLEAR;
        end
        RSI_CAUSE_DOG_RUN,
        RSI_CAUSE_SUPPLY: begin
          sp_load_q <= rsi_pkg::SP_TOP;
        end
      endcase
    end
  end

  // Reports only a low-supply reset that took effect; a watchdog in the same cycle wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_supply_reset_q <= 1'b0;
    end else if (clk_en) begin
      low_supply_reset_q <= (cause == RSI_CAUSE_SUPPLY);
    end
  end

  // Watchdog and time bases held clear through reset and the release edge, then counting starts
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      watchdog_clear_q <= 1'b1;
    end else if (clk_en) begin
      watchdog_clear_q <= !run_q;
    end
  end
endmodule : rsi_reset_init

// ===== sim/rsi_reset_init_assertions.sv
`timescale 1ns/1ps
module rsi_chk (
  // Design ports
  input wire logic clk_sys, nrst, clk_en, low_supply, watchdog_timeout, low_power_mode, powerdown_enter,
  input wire logic clear_watchdog,
  input wire logic core_reset_q, watchdog_expiry_flag_q, powerdown_entered_flag_q, state_load_q, full_init_q,
  input wire logic low_supply_reset_q, watchdog_clear_q,
  input wire logic [12:0] pc_load_q,
  input wire logic [3:0]  sp_load_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  dog_sleep_a: assert property (clk_en && watchdog_timeout && low_power_mode |=>
    watchdog_expiry_flag_q && powerdown_entered_flag_q && sp_load_q == 4'h0) else $error("sleep watchdog");
  dog_run_a: assert property (clk_en && watchdog_timeout && !low_power_mode |=>
    watchdog_expiry_flag_q && $stable(powerdown_entered_flag_q) && core_reset_q && pc_load_q == 13'h0000)
    else $error("run watchdog");
  supply_keep_a: assert property ($rose(low_supply_reset_q) |-> $stable(watchdog_expiry_flag_q) &&
    $stable(powerdown_entered_flag_q) && full_init_q && sp_load_q == 4'hF) else $error("low supply state");
  supply_qual_a: assert property (low_supply_reset_q |-> $past(low_supply, 25) && $past(low_supply))
    else $error("low supply too short");
  supply_sleep_a: assert property (clk_en && low_power_mode |=> !low_supply_reset_q)
    else $error("low supply in sleep");
  por_rel_a: assert property ($rose(nrst) |-> core_reset_q && full_init_q && !watchdog_expiry_flag_q &&
    !powerdown_entered_flag_q && sp_load_q == 4'hF ##1 state_load_q && watchdog_clear_q && !core_reset_q)
    else $error("release sequence");
  pd_set_a: assert property (clk_en && powerdown_enter && !watchdog_timeout ##1 !low_supply_reset_q |->
    powerdown_entered_flag_q && !watchdog_expiry_flag_q) else $error("powerdown flag");
  clr_a: assert property (clk_en && clear_watchdog && !watchdog_timeout && !powerdown_enter
    ##1 !low_supply_reset_q |-> !watchdog_expiry_flag_q && !powerdown_entered_flag_q) else $error("flag clear");
  cover property (clk_en && watchdog_timeout && low_power_mode);
  cover property ($rose(low_supply_reset_q));
  cover property ($rose(nrst));
endmodule : rsi_chk
bind rsi_reset_init rsi_chk u_chk (.*);

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0, nrst = 1'b0, ls = 1'b0, wd = 1'b0, lp = 1'b0, pe = 1'b0, cw = 1'b0, en = 1'b1;
  logic core_q, to_q, pd_q, sl_q, fi_q, lr_q, wc_q;
  logic [12:0] pc_q;
  logic [3:0] sp_q;
  int err_count = 0, n_compared = 0, n, n_fire = 0;
  // Rows: low power, watchdog, power-down, clear, then expected expiry flag, power-down flag, full init, stack
  logic [10:0] rows [6] = '{11'h12F, 11'h27F, 11'h08F, 11'h660, 11'h080, 11'h25F};
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (lr_q === 1'b1) n_fire++;
  rsi_reset_init uut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(en), .low_supply(ls), .watchdog_timeout(wd),
    .low_power_mode(lp), .powerdown_enter(pe), .clear_watchdog(cw), .core_reset_q(core_q),
    .watchdog_expiry_flag_q(to_q), .powerdown_entered_flag_q(pd_q), .pc_load_q(pc_q), .sp_load_q(sp_q),
    .state_load_q(sl_q), .full_init_q(fi_q), .low_supply_reset_q(lr_q), .watchdog_clear_q(wc_q));
  task chk(string nm, logic [12:0] exp, logic [12:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk
  task end_sim;
    $display("mismatches %0d of %0d compares", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 chk("por", 13'h00CF, {core_q, fi_q, to_q, pd_q, sp_q});
    @(posedge clk_sys) nrst <= 1'b1;
    @(posedge clk_sys) #1 chk("release", 13'h0005, {sl_q, core_q, wc_q});
    foreach (rows[i]) begin
      @(posedge clk_sys) {lp, wd, pe, cw} <= rows[i][10:7];
      @(posedge clk_sys) {lp, wd, pe, cw} <= 4'h0;
      #1 chk("flags", 13'(rows[i][6:5]), {to_q, pd_q});
      chk("core", 13'(rows[i][9]), core_q);
      chk("full_init", 13'(rows[i][4]), fi_q);
      chk("stack", 13'(rows[i][3:0]), sp_q);
    end
    // Frozen clock enable: a power-down entry must leave the flags alone
    @(posedge clk_sys) {en, pe} <= 2'h1;
    @(posedge clk_sys) {en, pe} <= 2'h2;
    #1 chk("frozen", 13'h0002, {to_q, pd_q});
    // Short dip first: the qualification count must restart
    @(posedge clk_sys) ls <= 1'b1;
    repeat (20) @(posedge clk_sys);
    ls <= 1'b0;
    @(posedge clk_sys) ls <= 1'b1;
    for (n = 0; n < 40 && lr_q !== 1'b1; n++) @(posedge clk_sys) #1;
    chk("supply_wait", 13'h0001, 13'(n >= 24 && n <= 26));
    chk("supply", 13'h00BF, {to_q, pd_q, fi_q, core_q, sp_q});
    chk("pc", 13'h0000, pc_q);
    @(posedge clk_sys) lp <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk("supply_fires", 13'h0001, 13'(n_fire));
    @(posedge clk_sys) nrst <= 1'b0;
    #1 chk("rerun", 13'h0000, {to_q, pd_q});
    end_sim();
  end
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule : testbench
